// ---- hw/idx_alu.sv ----
// Purpose: combinational result path of the execution slice
// Assumes: file_value is the addressed file register, already read
// Notes: zero is the result_null test of the 8-bit result
`timescale 1ns/10ps
`include "idx_cfg.svh"

module idx_alu
    import idx_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire idx_op_t op, // operation
    input wire logic [DATA_W-1:0] acc, // accumulator
    input wire logic [DATA_W-1:0] file_value, // addressed file register
    input wire logic [DATA_W-1:0] literal, // 8-bit immediate
    output logic [DATA_W-1:0] result, // operation result
    output logic zero // result is zero
);

    always_comb
    begin
        result = acc;
        unique case (op)
            IDX_OP_DECREMENT_FILE,
            IDX_OP_DECREMENT_SKIP_ON_NULL:
                result = DATA_W'(file_value - `IDX_ONE); // RQ2 RQ3
            IDX_OP_INCREMENT_FILE,
            IDX_OP_INCREMENT_SKIP_ON_NULL:
                result = DATA_W'(file_value + `IDX_ONE); // RQ5 RQ6
            IDX_OP_OR_IMMEDIATE_ACC:
                result = acc | literal; // RQ8
            IDX_OP_OR_ACC_WITH_FILE:
                result = acc | file_value; // RQ9
            IDX_OP_STORE_ACC_TO_FILE:
                result = acc; // RQ10
            default:
                result = acc;
        endcase
    end

    assign zero = (result == '0); // RQ11

endmodule : idx_alu

// ---- hw/idx_cfg.svh ----
// Purpose: constants for the increment/decrement/jump execution slice
// Assumes: included by bare name
// Notes: definitions only
`ifndef IDX_CFG_SVH
`define IDX_CFG_SVH

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IDX_ACC_RST 8'h00
`define IDX_ZERO_RST 1'b0
`define IDX_PC_RST 11'h000

// ---------------------------------------------------------------
// field positions, dest encodings and the increment/decrement step
// ---------------------------------------------------------------
`define IDX_PC_LOW_MSB 8
`define IDX_PC_PAGE_LSB 9
`define IDX_PC_PAGE_MSB 10
`define IDX_DEST_ACC 1'b0
`define IDX_DEST_FILE 1'b1
`define IDX_ONE 8'h01

`endif

// ---- hw/idx_exec.sv ----
// Purpose: executes decrement/increment (with skip), jump, OR and store
// Assumes: one operation offered per cycle, file operand read outside
// Notes: skip and jump squash the next offered (prefetched) operation
`timescale 1ns/10ps
`include "idx_cfg.svh"

// How it works
// RQ1: a file-register arithmetic or OR result goes to the accumulator when dest is 0, else to the file register.
// RQ2: decrement_file writes file minus one to the destination and updates only the null flag.
// RQ3: decrement_skip_on_null writes file minus one to the destination and touches no flag.
// RQ4: a skip instruction whose result is zero discards the prefetched instruction, running a no-op instead.
// RQ5: increment_file writes file plus one to the destination and updates the null flag.
// RQ6: increment_skip_on_null writes file plus one, skips on zero and touches no flag.
// RQ7: jump_absolute loads pc low nine bits from the literal and pc bits 10:9 from status bits 6:5.
// RQ8: or_immediate_acc ORs the accumulator with an 8-bit literal into the accumulator, updating the null flag.
// RQ9: or_acc_with_file ORs accumulator and file into the destination, updating the null flag.
// RQ10: store_acc_to_file copies the accumulator into the addressed file register, flags untouched.
// RQ11: the null flag is set when the 8-bit result is zero and cleared otherwise.
// RQ12: jump_absolute takes two cycles, discarding the instruction prefetched during it.
module idx_exec
    import idx_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 5,
    parameter int LIT_W = 9,
    parameter int PC_W = 11
)
(
    input wire logic clk, // 125 MHz instruction clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic op_valid, // operation offered this cycle
    input wire idx_op_t op_code, // operation to execute
    input wire logic op_dest, // 0 accumulator, 1 file register
    input wire logic [ADDR_W-1:0] op_addr, // file register address
    input wire logic [LIT_W-1:0] op_literal, // literal, 8 or 9 bits used
    input wire logic [DATA_W-1:0] file_value, // contents of op_addr
    input wire logic [1:0] status_page, // status bits 6:5
    output logic op_taken, // operation accepted (not squashed)
    output logic op_squashed, // offered operation discarded as no-op
    output logic [DATA_W-1:0] acc, // accumulator
    output logic null_flag, // result_null_flag
    output logic null_flag_we, // pulse: null flag updated
    output logic file_we, // pulse: file register write
    output logic [ADDR_W-1:0] file_waddr, // file write address
    output logic [DATA_W-1:0] file_wdata, // file write data
    output logic pc_load, // pulse: load program counter
    output logic [PC_W-1:0] pc_target // program counter value
);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    idx_state_t state;
    logic [DATA_W-1:0] result;
    logic result_zero;
    logic is_file_op;
    logic is_skip_op;
    logic updates_flag;
    logic next_squash;
    idx_state_t next_state;
    logic is_jump_op;
    logic is_store_op;
    logic is_acc_lit_op;
    logic acc_we;
    logic next_file_we;
    logic next_null_flag_we;
    logic next_pc_load;

    // the squash slot waits for the next real offer; idle cycles with
    // op_valid low leave the prefetched operation still to be swallowed
    assign op_squashed = op_valid && (state == IDX_ST_SQUASH); // RQ4 RQ12
    assign op_taken = op_valid && (state == IDX_ST_RUN);

    // one row per operation; codes outside the table act as a no-op
    always_comb
    begin
        is_skip_op = 1'b0;
        is_file_op = 1'b0;
        updates_flag = 1'b0;
        is_jump_op = 1'b0;
        is_store_op = 1'b0;
        is_acc_lit_op = 1'b0;
        unique case (op_code)
            IDX_OP_NOP:
            begin
                is_file_op = 1'b0;
            end
            IDX_OP_DECREMENT_FILE:
            begin
                is_file_op = 1'b1;
                updates_flag = 1'b1; // RQ2
            end
            IDX_OP_DECREMENT_SKIP_ON_NULL:
            begin
                is_file_op = 1'b1;
                is_skip_op = 1'b1; // RQ3
            end
            IDX_OP_INCREMENT_FILE:
            begin
                is_file_op = 1'b1;
                updates_flag = 1'b1; // RQ5
            end
            IDX_OP_INCREMENT_SKIP_ON_NULL:
            begin
                is_file_op = 1'b1;
                is_skip_op = 1'b1; // RQ6
            end
            IDX_OP_JUMP_ABSOLUTE:
            begin
                is_jump_op = 1'b1; // RQ12
            end
            IDX_OP_OR_IMMEDIATE_ACC:
            begin
                is_acc_lit_op = 1'b1;
                updates_flag = 1'b1; // RQ8
            end
            IDX_OP_OR_ACC_WITH_FILE:
            begin
                is_file_op = 1'b1;
                updates_flag = 1'b1; // RQ9
            end
            IDX_OP_STORE_ACC_TO_FILE:
            begin
                is_store_op = 1'b1; // RQ10
            end
            default:
            begin
                is_file_op = 1'b0;
            end
        endcase
    end

    assign next_squash = op_taken
        && ((is_skip_op && result_zero) || is_jump_op); // RQ4 RQ6 RQ12

    // ---------------------------------------------------------------
    // write enables
    // ---------------------------------------------------------------
    // literal OR ignores dest, so it always lands in the accumulator
    assign acc_we = op_taken
        && (is_acc_lit_op || (is_file_op && (op_dest == `IDX_DEST_ACC))); // RQ1 RQ8
    assign next_file_we = op_taken
        && (is_store_op || (is_file_op && (op_dest == `IDX_DEST_FILE))); // RQ1 RQ10
    assign next_null_flag_we = op_taken && updates_flag; // RQ11
    assign next_pc_load = op_taken && is_jump_op; // RQ7

    // ---------------------------------------------------------------
    // result path
    // ---------------------------------------------------------------
    idx_alu #(
        .DATA_W(DATA_W)
    ) u_alu (
        .op(op_code),
        .acc(acc),
        .file_value(file_value),
        .literal(op_literal[DATA_W-1:0]),
        .result(result),
        .zero(result_zero)
    );

    // ---------------------------------------------------------------
    // squash sequencing
    // ---------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            IDX_ST_RUN:
            begin
                if (next_squash)
                begin
                    next_state = IDX_ST_SQUASH; // RQ4 RQ12
                end
            end
            IDX_ST_SQUASH:
            begin
                // only a real offer spends the squash slot
                if (op_valid)
                begin
                    next_state = IDX_ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= IDX_ST_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // accumulator
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc <= `IDX_ACC_RST;
        end
        else if (acc_we)
        begin
            acc <= result; // RQ1 RQ8
        end
    end

    // ---------------------------------------------------------------
    // result_null_flag
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            null_flag <= `IDX_ZERO_RST;
        end
        else if (next_null_flag_we)
        begin
            null_flag <= result_zero; // RQ11
        end
    end

    // strobe lines up with the edge that moves the flag
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            null_flag_we <= 1'b0;
        end
        else
        begin
            null_flag_we <= next_null_flag_we; // RQ2 RQ5
        end
    end

    // ---------------------------------------------------------------
    // file register write port
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            file_we <= 1'b0;
        end
        else
        begin
            file_we <= next_file_we; // RQ1 RQ10
        end
    end

    // address and data hold after the pulse, so a slow consumer may
    // latch them a cycle late
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            file_waddr <= '0;
            file_wdata <= '0;
        end
        else if (next_file_we)
        begin
            file_waddr <= op_addr;
            file_wdata <= result;
        end
    end

    // ---------------------------------------------------------------
    // program counter load
    // ---------------------------------------------------------------
    // one pulse per taken jump, high in the cycle after it, the same cycle the squash slot opens
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pc_load <= 1'b0;
        end
        else
        begin
            pc_load <= next_pc_load; // RQ7
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pc_target <= `IDX_PC_RST;
        end
        else if (next_pc_load)
        begin
            // page bits come from status, not the literal
            pc_target[`IDX_PC_LOW_MSB:0] <= op_literal; // RQ7
            pc_target[`IDX_PC_PAGE_MSB:`IDX_PC_PAGE_LSB] <= status_page; // RQ7
        end
    end

endmodule : idx_exec

// ---- hw/idx_pkg.sv ----
// Purpose: types for the execution slice
// Assumes: constants live in idx_cfg.svh
// Notes: opcode codes are internal, not the instruction encoding
package idx_pkg;

    typedef enum logic [3:0] {
        IDX_OP_NOP = 4'h0,
        IDX_OP_DECREMENT_FILE = 4'h1,
        IDX_OP_DECREMENT_SKIP_ON_NULL = 4'h2,
        IDX_OP_INCREMENT_FILE = 4'h3,
        IDX_OP_INCREMENT_SKIP_ON_NULL = 4'h4,
        IDX_OP_JUMP_ABSOLUTE = 4'h5,
        IDX_OP_OR_IMMEDIATE_ACC = 4'h6,
        IDX_OP_OR_ACC_WITH_FILE = 4'h7,
        IDX_OP_STORE_ACC_TO_FILE = 4'h8
    } idx_op_t;

    typedef enum logic [0:0] {
        IDX_ST_RUN = 1'b0,
        IDX_ST_SQUASH = 1'b1
    } idx_state_t;

endpackage : idx_pkg

// ---- tb/idx_exec_monitor.sv ----
// Purpose: concurrent checks on the execution slice ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to idx_exec below
`timescale 1ns/10ps

module idx_exec_monitor
    import idx_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic op_valid, // offer
    input wire idx_op_t op_code, // op
    input wire logic op_dest, // dest
    input wire logic [4:0] op_addr, // addr
    input wire logic [8:0] op_literal, // literal
    input wire logic [7:0] file_value, // file
    input wire logic [1:0] status_page, // page
    input wire logic op_taken, // taken
    input wire logic op_squashed, // squashed
    input wire logic [7:0] acc, // acc
    input wire logic null_flag, // flag
    input wire logic null_flag_we, // flag we
    input wire logic file_we, // file we
    input wire logic [4:0] file_waddr, // waddr
    input wire logic [7:0] file_wdata, // wdata
    input wire logic pc_load, // pc load
    input wire logic [10:0] pc_target // pc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_dest;
        op_taken && op_code == IDX_OP_DECREMENT_FILE && !op_dest
        |=> !file_we && acc == $past(file_value) - 8'h01;
    endproperty
    a_dest: assert property (p_dest) else $error("dest acc wrong");
    property p_dec;
        op_taken && op_code == IDX_OP_DECREMENT_FILE
        |=> null_flag_we && null_flag == ($past(file_value) == 8'h01);
    endproperty
    a_dec: assert property (p_dec) else $error("dec flag wrong");
    property p_inc;
        op_taken && op_code == IDX_OP_INCREMENT_FILE
        |=> null_flag_we && null_flag == ($past(file_value) == 8'hFF);
    endproperty
    a_inc: assert property (p_inc) else $error("inc flag wrong");
    property p_noflag;
        op_taken && op_code inside {IDX_OP_DECREMENT_SKIP_ON_NULL, IDX_OP_INCREMENT_SKIP_ON_NULL}
        |=> !null_flag_we && $stable(null_flag);
    endproperty
    a_noflag: assert property (p_noflag) else $error("skip op touched flag");
    property p_skip;
        op_taken && (op_code == IDX_OP_INCREMENT_SKIP_ON_NULL && file_value == 8'hFF
        || op_code == IDX_OP_DECREMENT_SKIP_ON_NULL && file_value == 8'h01)
        ##1 op_valid |-> op_squashed;
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");
    property p_jmp;
        op_taken && op_code == IDX_OP_JUMP_ABSOLUTE
        |=> pc_load && pc_target == {$past(status_page), $past(op_literal)};
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong");
    property p_jsq;
        op_taken && op_code == IDX_OP_JUMP_ABSOLUTE ##1 op_valid |-> op_squashed;
    endproperty
    a_jsq: assert property (p_jsq) else $error("jump prefetch kept");
    property p_orf;
        op_taken && op_code == IDX_OP_OR_ACC_WITH_FILE && op_dest
        |=> file_we && file_wdata == ($past(acc) | $past(file_value))
        && null_flag == (file_wdata == 8'h00);
    endproperty
    a_orf: assert property (p_orf) else $error("or file wrong");
    property p_store;
        op_taken && op_code == IDX_OP_STORE_ACC_TO_FILE |=> file_we && !null_flag_we
        && file_wdata == $past(acc) && file_waddr == $past(op_addr);
    endproperty
    a_store: assert property (p_store) else $error("store wrong");
    property p_orl;
        op_taken && op_code == IDX_OP_OR_IMMEDIATE_ACC
        |=> acc == ($past(acc) | $past(op_literal[7:0])) && null_flag_we && !file_we;
    endproperty
    a_orl: assert property (p_orl) else $error("or literal wrong");
endmodule : idx_exec_monitor

bind idx_exec idx_exec_monitor mon (.clk, .rst_n, .op_valid, .op_code, .op_dest, .op_addr,
    .op_literal, .file_value, .status_page, .op_taken, .op_squashed, .acc, .null_flag,
    .null_flag_we, .file_we, .file_waddr, .file_wdata, .pc_load, .pc_target);

// ---- tb/increment_decrement_or_jump_exec_tb.sv ----
// Purpose: directed scenarios for the execution slice
// Assumes: outputs other than op_taken and op_squashed registered one cycle after the offer
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps

module increment_decrement_or_jump_exec_tb
    import idx_pkg::*;
;
    logic clk = 0, rst_n = 0, op_valid = 0, op_dest = 0;
    idx_op_t op_code = IDX_OP_NOP;
    logic [4:0] op_addr = 5'h00, file_waddr;
    logic [8:0] op_literal = 9'h000;
    logic [7:0] file_value = 8'h00, acc, file_wdata;
    logic [1:0] status_page = 2'h0;
    logic op_taken, op_squashed, null_flag, null_flag_we, file_we, pc_load;
    logic [10:0] pc_target;
    int n_mismatch = 0, cmp_count = 0;
    always #4 clk = ~clk;
    idx_exec uut (.clk, .rst_n, .op_valid, .op_code, .op_dest, .op_addr, .op_literal,
        .file_value, .status_page, .op_taken, .op_squashed, .acc, .null_flag,
        .null_flag_we, .file_we, .file_waddr, .file_wdata, .pc_load, .pc_target);
    task chk(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // nop offers are idle cycles, so they never use up a squash slot
    task op(input idx_op_t c, input logic d, input logic [4:0] a, input logic [8:0] l,
            input logic [7:0] f);
        @(posedge clk);
        #1;
        op_valid = c != IDX_OP_NOP;
        op_code = c;
        op_dest = d;
        op_addr = a;
        op_literal = l;
        file_value = f;
    endtask : op
    task t_dec;
        op(IDX_OP_DECREMENT_FILE, 0, 5'h02, 9'h000, 8'h01);
        op(IDX_OP_DECREMENT_FILE, 1, 5'h1F, 9'h000, 8'h00);
        chk(acc, 8'h00);
        chk(null_flag, 1'b1);
        chk(file_we, 1'b0);
        chk(op_taken, 1'b1);
        op(IDX_OP_INCREMENT_FILE, 1, 5'h03, 9'h000, 8'hFF);
        chk(file_wdata, 8'hFF);
        chk(file_waddr, 5'h1F);
        chk(null_flag, 1'b0);
    endtask : t_dec
    task t_skip;
        op(IDX_OP_INCREMENT_SKIP_ON_NULL, 0, 5'h04, 9'h000, 8'hFF);
        chk(file_wdata, 8'h00);
        chk(null_flag, 1'b1);
        op(IDX_OP_INCREMENT_FILE, 1, 5'h05, 9'h000, 8'h10);
        chk(op_squashed, 1'b1);
        chk(acc, 8'h00);
        chk(op_taken, 1'b0);
        chk(null_flag_we, 1'b0);
        op(IDX_OP_DECREMENT_SKIP_ON_NULL, 0, 5'h06, 9'h000, 8'h05);
        chk(file_we, 1'b0);
        op(IDX_OP_DECREMENT_SKIP_ON_NULL, 1, 5'h07, 9'h000, 8'h01);
        chk(op_squashed, 1'b0);
        chk(acc, 8'h04);
        op(IDX_OP_STORE_ACC_TO_FILE, 0, 5'h08, 9'h000, 8'h00);
        chk(op_squashed, 1'b1);
        chk(null_flag, 1'b1);
    endtask : t_skip
    task t_jmp_or;
        status_page = 2'h2;
        op(IDX_OP_JUMP_ABSOLUTE, 0, 5'h00, 9'h1A5, 8'h00);
        op(IDX_OP_OR_IMMEDIATE_ACC, 0, 5'h00, 9'h0FF, 8'h00);
        chk(op_squashed, 1'b1);
        chk(pc_load, 1'b1);
        chk(pc_target, 11'h5A5);
        op(IDX_OP_OR_IMMEDIATE_ACC, 1, 5'h00, 9'h130, 8'h00);
        chk(acc, 8'h04);
        op(IDX_OP_OR_ACC_WITH_FILE, 1, 5'h09, 9'h000, 8'h41);
        chk(acc, 8'h34);
        chk(null_flag_we, 1'b1);
        op(IDX_OP_STORE_ACC_TO_FILE, 1, 5'h1F, 9'h000, 8'h00);
        chk(file_wdata, 8'h75);
        chk(file_waddr, 5'h09);
        op(IDX_OP_NOP, 0, 5'h00, 9'h000, 8'h00);
        chk(file_wdata, 8'h34);
        chk(file_waddr, 5'h1F);
        chk(null_flag_we, 1'b0);
    endtask : t_jmp_or
    task results;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        chk(acc, 8'h00);
        chk(pc_target, 11'h000);
        rst_n = 1;
        t_dec();
        t_skip();
        t_jmp_or();
        repeat (2) @(posedge clk);
        results();
    end
endmodule : increment_decrement_or_jump_exec_tb
